// [rcpd_defs.vh]
`ifndef RCPD_DEFS_VH
`define RCPD_DEFS_VH

// register offsets on the host port
`define RCPD_OFS_ITER_HIGH    8'h00
`define RCPD_OFS_ITER_LOW     8'h01
`define RCPD_OFS_REPETITION   8'h02
`define RCPD_OFS_THRESHOLD    8'h03
`define RCPD_OFS_PULSE_TIMING 8'h04
`define RCPD_OFS_PIN_CONTROL  8'h05
`define RCPD_OFS_ALG_OPTION   8'h06
`define RCPD_OFS_COMMAND      8'h10
`define RCPD_OFS_STATUS       8'h11
`define RCPD_OFS_IRQ_ENABLE   8'h12
`define RCPD_OFS_TRANS_ID     8'h13

// reset values
`define RCPD_RST_ALG_OPTION   8'h03
`define RCPD_RST_PIN_CONTROL  8'h44
`define RCPD_RST_ZERO         8'h00

// command codes
`define RCPD_CMD_START        8'h03

// algorithm option byte fields
`define RCPD_ALG_CLK_HALF     2
`define RCPD_ALG_IMM_IRQ      4
`define RCPD_ALG_COMBINED     5
`define RCPD_ALG_STAY_AWAKE   7

// threshold byte fields
`define RCPD_THR_LEVEL        5:0
`define RCPD_THR_SPREAD       6

// status fields
`define RCPD_STS_BUSY         0
`define RCPD_STS_IRQ          1
`define RCPD_STS_GATE         2

// pin configuration codes
`define RCPD_PIN_INPUT        4'h0
`define RCPD_PIN_GATE_LOW     4'h1
`define RCPD_PIN_GATE_HIGH    4'h2
`define RCPD_PIN_MARKER       4'h3
`define RCPD_PIN_DRIVE_LOW    4'h4
`define RCPD_PIN_DRIVE_HIGH   4'h5

// timing
`define RCPD_CLK_MHZ          100
`define RCPD_LEAD_STEP_US     100
`define RCPD_MS_US            1000

`endif

// [rcpd_top.v]
// Summary of operation
// RULE1 - start command launches measurement using the seven loaded parameter bytes
// RULE2 - option bit 2 halves emitter clock and doubles emitter-active time
// RULE3 - host writes ones to option bits 0,1 and zeros to reserved bits
// RULE4 - option bit 4 raises interrupt at once on pin-triggered capture
// RULE5 - option bit 5 captures short and long histograms together
// RULE6 - option bit 7 keeps device out of standby between measurements
// RULE7 - pin control byte: low nibble first pin, high nibble second pin
// RULE8 - code 1: low input abandons measurement, high restarts it
// RULE9 - code 2: high input abandons measurement, low restarts it
// RULE10 - codes 0 input, 3 marker, 4 drive low default, 5 drive high
// RULE11 - pulse timing: 0 no marker, 1 at emitter start, each step 100 us earlier
// RULE12 - marker falls when emitter stops emitting
// RULE13 - threshold bits 5:0 set detection threshold
// RULE14 - threshold bit 6 enables spread spectrum mode
// RULE15 - repetition byte is period in ms, zero means single measurement
// RULE16 - period shorter than ranging time repeats as fast as possible
// RULE17 - iteration count high and low bytes, low step 1k, high step 256k
// RULE18 - completion asserts interrupt if enabled and updates transaction id
// RULE19 - host writes all parameter bytes before the command byte
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`include "rcpd_defs.vh"

module rcpd_top #(
   parameter LEAD_STEP_CYCLES  = `RCPD_LEAD_STEP_US * `RCPD_CLK_MHZ,
   parameter MS_CYCLES         = `RCPD_MS_US * `RCPD_CLK_MHZ,
   parameter EMIT_KITER_CYCLES = 64,
   parameter NUM_PINS          = 2
) (
   // clock and reset
   input  wire                clock,
   input  wire                sys_rst,
   // register port
   input  wire [7:0]          reg_addr,
   input  wire [7:0]          reg_wdata,
   input  wire                reg_write,
   input  wire                reg_read,
   output reg  [7:0]          reg_rdata,
   // general pins, index 0 first pin, index 1 second pin
   input  wire [NUM_PINS-1:0] general_pin_in,
   output reg  [NUM_PINS-1:0] general_pin_out,
   output reg  [NUM_PINS-1:0] general_pin_oe,
   // measurement engine controls
   output reg                 emitter_on,
   output reg                 emitter_clock_halving,
   output reg                 combined_histogram,
   output reg                 standby,
   output reg  [5:0]          detect_threshold,
   output reg                 spread_spectrum,
   output reg                 measurement_busy,
   // host interrupt and transaction id
   output reg                 measurement_irq,
   output reg  [7:0]          transaction_id
);

   // sequencer states, plain binary codes
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_LEAD = 3'h1;
   localparam [2:0] ST_EMIT = 3'h2;
   localparam [2:0] ST_WAIT = 3'h3;
   localparam [2:0] ST_HOLD = 3'h4;
   localparam [2:0] ST_ARM  = 3'h5;

   // host-loaded parameter bytes
   reg  [7:0]  iter_high_reg;
   reg  [7:0]  iter_low_reg;
   reg  [7:0]  repetition_reg;
   reg  [7:0]  threshold_reg;
   reg  [7:0]  pulse_timing_reg;
   reg  [7:0]  pin_control_reg;
   reg  [7:0]  alg_option_reg;
   reg  [7:0]  command_reg;
   reg         irq_enable_reg;
   reg         irq_pending_reg;
   reg  [7:0]  tid_reg;

   // snapshot taken at the start command
   reg  [7:0]  act_iter_high_reg;
   reg  [7:0]  act_iter_low_reg;
   reg  [7:0]  act_repetition_reg;
   reg  [7:0]  act_threshold_reg;
   reg  [7:0]  act_pulse_reg;
   reg  [7:0]  act_pin_reg;
   reg  [7:0]  act_option_reg;

   // measurement sequencer
   reg  [2:0]  state_reg;
   reg  [2:0]  state_next;
   reg  [31:0] count_reg;
   reg  [31:0] count_next;
   reg  [31:0] ms_pre_reg;
   reg  [7:0]  ms_elapsed_reg;
   reg         restart_ms;
   reg         done_pulse;
   reg         pin_event_pulse;

   // strobe decodes shared by the sequencer and the register file
   wire        wr_cmd   = reg_write && (reg_addr == `RCPD_OFS_COMMAND);
   wire        start_wr = wr_cmd && (reg_wdata == `RCPD_CMD_START);
   wire        clr_irq  = reg_write && (reg_addr == `RCPD_OFS_STATUS)
                          && reg_wdata[`RCPD_STS_IRQ];

   // per-pin synchroniser, gate detection and output drive
   wire [NUM_PINS-1:0] gate_vec;
   wire [NUM_PINS-1:0] drv_out;
   wire [NUM_PINS-1:0] drv_oe;
   wire                marker_on;

   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g = g + 1) begin : pin_gen
         reg        sync1_reg;
         reg        sync2_reg;
         reg        sync3_reg;
         reg        level_reg;
         wire [3:0] code = act_pin_reg[4*g+3:4*g]; // RULE7
         // three stages; first one feeds only the second
         always @(posedge clock) begin
            if (sys_rst) begin
               sync1_reg <= 1'b1;
               sync2_reg <= 1'b1;
               sync3_reg <= 1'b1;
               level_reg <= 1'b1;
            end else begin
               sync1_reg <= general_pin_in[g];
               sync2_reg <= sync1_reg;
               sync3_reg <= sync2_reg;
               if (sync2_reg == sync3_reg) begin
                  level_reg <= sync3_reg;
               end
            end
         end
         // gating inputs hold off collection while active
         assign gate_vec[g] = ((code == `RCPD_PIN_GATE_LOW) && !level_reg) // RULE8
                            || ((code == `RCPD_PIN_GATE_HIGH) && level_reg); // RULE9
         // reserved codes fall back to a plain input, safer than driving
         assign drv_oe[g]  = (code == `RCPD_PIN_MARKER) || (code == `RCPD_PIN_DRIVE_LOW)
                             || (code == `RCPD_PIN_DRIVE_HIGH); // RULE10
         assign drv_out[g] = ((code == `RCPD_PIN_MARKER) && marker_on)
                             || (code == `RCPD_PIN_DRIVE_HIGH); // RULE10
      end
   endgenerate

   // any gating pin holds off the whole measurement, not just its own
   wire gate_any = |gate_vec;

   // emitter time: iterations in thousands times cycles per thousand
   wire [15:0] kiter     = {act_iter_high_reg, act_iter_low_reg}; // RULE17
   wire [63:0] emit_prod = kiter * EMIT_KITER_CYCLES;
   wire [31:0] emit_base = emit_prod[31:0];
   wire [31:0] emit_len  = act_option_reg[`RCPD_ALG_CLK_HALF] ?
                           {emit_base[30:0], 1'b0} : emit_base; // RULE2

   // lead of marker before emitter; code 1 has none
   wire [7:0]  lead_steps = (act_pulse_reg > 8'h01) ? (act_pulse_reg - 8'h01) : 8'h00;
   wire [63:0] lead_prod  = lead_steps * LEAD_STEP_CYCLES; // RULE11
   wire [31:0] lead_len   = lead_prod[31:0];

   // marker high during lead and emission, unless timing byte is zero;
   // a gate drops it in the same cycle as the emitter, not one later
   assign marker_on = (act_pulse_reg != 8'h00)
                      && ((state_reg == ST_LEAD) || (state_reg == ST_EMIT)) // RULE11
                      && !gate_any; // RULE12

   // sequencer next state
   always @* begin
      state_next      = state_reg;
      count_next      = count_reg;
      restart_ms      = 1'b0;
      done_pulse      = 1'b0;
      pin_event_pulse = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (start_wr) begin
               state_next = ST_ARM;
            end
         end
         ST_ARM: begin
            restart_ms = 1'b1; // RULE1
            if (gate_any) begin
               state_next = ST_HOLD;
            end else if (lead_len != 32'h0000_0000) begin
               state_next = ST_LEAD;
               count_next = lead_len;
            end else begin
               state_next = ST_EMIT;
               count_next = emit_len;
            end
         end
         ST_LEAD: begin
            if (gate_any) begin
               state_next = ST_HOLD; // RULE8
            end else if (count_reg <= 32'h0000_0001) begin
               state_next = ST_EMIT;
               count_next = emit_len;
            end else begin
               count_next = count_reg - 32'h0000_0001;
            end
         end
         ST_EMIT: begin
            if (gate_any) begin
               state_next = ST_HOLD; // RULE9
            end else if (count_reg <= 32'h0000_0001) begin
               done_pulse = 1'b1; // RULE12
               if (act_repetition_reg == 8'h00) begin
                  state_next = ST_IDLE; // RULE15
               end else if (ms_elapsed_reg >= act_repetition_reg) begin
                  state_next = ST_ARM; // RULE16
               end else begin
                  state_next = ST_WAIT;
               end
            end else begin
               count_next = count_reg - 32'h0000_0001;
            end
         end
         ST_WAIT: begin
            if (gate_any) begin
               state_next = ST_HOLD;
            end else if (ms_elapsed_reg >= act_repetition_reg) begin
               state_next = ST_ARM; // RULE15
            end
         end
         ST_HOLD: begin
            if (!gate_any) begin
               state_next      = ST_ARM; // RULE8
               pin_event_pulse = 1'b1;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      // a new start command overrides any running sequence
      if (start_wr && (state_reg != ST_IDLE)) begin
         state_next = ST_ARM;
      end
   end

   // sequencer registers and elapsed-time counter
   always @(posedge clock) begin
      if (sys_rst) begin
         state_reg      <= ST_IDLE;
         count_reg      <= 32'h0000_0000;
         ms_pre_reg     <= 32'h0000_0000;
         ms_elapsed_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         if (restart_ms) begin
            ms_pre_reg     <= 32'h0000_0000;
            ms_elapsed_reg <= 8'h00;
         end else if (ms_pre_reg >= MS_CYCLES - 1) begin
            ms_pre_reg <= 32'h0000_0000;
            if (ms_elapsed_reg != 8'hFF) begin
               ms_elapsed_reg <= ms_elapsed_reg + 8'h01; // saturates, period fits 8 bits
            end
         end else begin
            ms_pre_reg <= ms_pre_reg + 32'h0000_0001;
         end
      end
   end

   // register writes, snapshot on start, interrupt and transaction id
   always @(posedge clock) begin
      if (sys_rst) begin
         iter_high_reg      <= `RCPD_RST_ZERO;
         iter_low_reg       <= `RCPD_RST_ZERO;
         repetition_reg     <= `RCPD_RST_ZERO;
         threshold_reg      <= `RCPD_RST_ZERO;
         pulse_timing_reg   <= `RCPD_RST_ZERO;
         pin_control_reg    <= `RCPD_RST_PIN_CONTROL;
         alg_option_reg     <= `RCPD_RST_ALG_OPTION;
         command_reg        <= `RCPD_RST_ZERO;
         irq_enable_reg     <= 1'b0;
         irq_pending_reg    <= 1'b0;
         tid_reg            <= `RCPD_RST_ZERO;
         act_iter_high_reg  <= `RCPD_RST_ZERO;
         act_iter_low_reg   <= `RCPD_RST_ZERO;
         act_repetition_reg <= `RCPD_RST_ZERO;
         act_threshold_reg  <= `RCPD_RST_ZERO;
         act_pulse_reg      <= `RCPD_RST_ZERO;
         act_pin_reg        <= `RCPD_RST_PIN_CONTROL;
         act_option_reg     <= `RCPD_RST_ALG_OPTION;
      end else begin
         if (reg_write) begin
            case (reg_addr)
               `RCPD_OFS_ITER_HIGH:    iter_high_reg    <= reg_wdata;
               `RCPD_OFS_ITER_LOW:     iter_low_reg     <= reg_wdata;
               `RCPD_OFS_REPETITION:   repetition_reg   <= reg_wdata;
               `RCPD_OFS_THRESHOLD:    threshold_reg    <= reg_wdata;
               `RCPD_OFS_PULSE_TIMING: pulse_timing_reg <= reg_wdata;
               `RCPD_OFS_PIN_CONTROL:  pin_control_reg  <= reg_wdata;
               `RCPD_OFS_ALG_OPTION:   alg_option_reg   <= reg_wdata; // RULE3
               `RCPD_OFS_COMMAND:      command_reg      <= reg_wdata;
               `RCPD_OFS_IRQ_ENABLE:   irq_enable_reg   <= reg_wdata[0];
               default: begin
               end
            endcase
         end
         // bytes are taken whole at the command; host loads them first
         if (start_wr) begin
            act_iter_high_reg  <= iter_high_reg; // RULE19
            act_iter_low_reg   <= iter_low_reg;
            act_repetition_reg <= repetition_reg;
            act_threshold_reg  <= threshold_reg;
            act_pulse_reg      <= pulse_timing_reg;
            act_pin_reg        <= pin_control_reg;
            act_option_reg     <= alg_option_reg; // RULE1
         end
         // set beats a clear landing in the same cycle
         if (done_pulse || (pin_event_pulse && act_option_reg[`RCPD_ALG_IMM_IRQ])) begin
            irq_pending_reg <= 1'b1; // RULE4
         end else if (clr_irq) begin
            irq_pending_reg <= 1'b0;
         end
         if (done_pulse) begin
            tid_reg <= tid_reg + 8'h01; // RULE18
         end
      end
   end

   // registered outputs
   always @(posedge clock) begin
      if (sys_rst) begin
         reg_rdata             <= 8'h00;
         general_pin_out       <= {NUM_PINS{1'b0}};
         general_pin_oe        <= {NUM_PINS{1'b1}};
         emitter_on            <= 1'b0;
         emitter_clock_halving <= 1'b0;
         combined_histogram    <= 1'b0;
         standby               <= 1'b1;
         detect_threshold      <= 6'h00;
         spread_spectrum       <= 1'b0;
         measurement_busy      <= 1'b0;
         measurement_irq       <= 1'b0;
         transaction_id        <= 8'h00;
      end else begin
         general_pin_out       <= drv_out;
         general_pin_oe        <= drv_oe;
         emitter_on            <= (state_reg == ST_EMIT) && !gate_any; // RULE12
         emitter_clock_halving <= act_option_reg[`RCPD_ALG_CLK_HALF]; // RULE2
         combined_histogram    <= act_option_reg[`RCPD_ALG_COMBINED]; // RULE5
         // standby only between measurements, unless told to stay awake
         standby               <= ((state_reg == ST_IDLE) || (state_reg == ST_WAIT))
                                  && !act_option_reg[`RCPD_ALG_STAY_AWAKE]; // RULE6
         detect_threshold      <= act_threshold_reg[`RCPD_THR_LEVEL]; // RULE13
         spread_spectrum       <= act_threshold_reg[`RCPD_THR_SPREAD]; // RULE14
         measurement_busy      <= (state_reg != ST_IDLE);
         measurement_irq       <= irq_pending_reg && irq_enable_reg; // RULE18
         transaction_id        <= tid_reg;
         // read data valid only in the cycle after the strobe
         if (reg_read) begin
            case (reg_addr)
               `RCPD_OFS_ITER_HIGH:    reg_rdata <= iter_high_reg;
               `RCPD_OFS_ITER_LOW:     reg_rdata <= iter_low_reg;
               `RCPD_OFS_REPETITION:   reg_rdata <= repetition_reg;
               `RCPD_OFS_THRESHOLD:    reg_rdata <= threshold_reg;
               `RCPD_OFS_PULSE_TIMING: reg_rdata <= pulse_timing_reg;
               `RCPD_OFS_PIN_CONTROL:  reg_rdata <= pin_control_reg;
               `RCPD_OFS_ALG_OPTION:   reg_rdata <= alg_option_reg;
               `RCPD_OFS_COMMAND:      reg_rdata <= command_reg;
               `RCPD_OFS_STATUS:       reg_rdata <= {5'h00, gate_any, irq_pending_reg,
                                                     (state_reg != ST_IDLE)};
               `RCPD_OFS_IRQ_ENABLE:   reg_rdata <= {7'h00, irq_enable_reg};
               `RCPD_OFS_TRANS_ID:     reg_rdata <= tid_reg;
               default:                reg_rdata <= 8'h00;
            endcase
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

endmodule

// [rcpd_assertions.sv]
`timescale 1ns/10ps
module rcpd_assertions #(
   parameter NUM_PINS = 2
) (
   // clock and reset
   input logic                clock,
   input logic                sys_rst,
   // register port
   input logic [7:0]          reg_addr,
   input logic [7:0]          reg_wdata,
   input logic                reg_write,
   input logic                reg_read,
   input logic [7:0]          reg_rdata,
   // pins and engine
   input logic [NUM_PINS-1:0] general_pin_out,
   input logic [NUM_PINS-1:0] general_pin_oe,
   input logic                emitter_on,
   input logic                standby,
   input logic [5:0]          detect_threshold,
   input logic                spread_spectrum,
   input logic                measurement_busy,
   input logic [7:0]          transaction_id
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   // values seen on the first cycle out of reset
   chk_reset_state: assert property ($fell(sys_rst) |-> general_pin_oe == {NUM_PINS{1'b1}}
      && general_pin_out == '0 && !emitter_on && standby && transaction_id == 8'h00)
      else $error("outputs not at reset state");
   chk_start_busy: assert property (reg_write && reg_addr == 8'h10 && reg_wdata == 8'h03
      |-> ##[1:3] measurement_busy)
      else $error("start command did not launch");
   // other codes are stored only
   chk_other_idle: assert property (!measurement_busy && reg_write && reg_addr == 8'h10
      && reg_wdata != 8'h03 |=> !measurement_busy)
      else $error("unknown command launched");
   chk_emit_busy: assert property (emitter_on |-> measurement_busy || $past(measurement_busy))
      else $error("emitter on while idle");
   chk_awake_emit: assert property (emitter_on |-> !standby)
      else $error("standby while emitting");
   chk_tid_step: assert property ($changed(transaction_id)
      |-> transaction_id == $past(transaction_id) + 8'h01)
      else $error("transaction id jumped");
   chk_tid_read: assert property (reg_read && reg_addr == 8'h13 |=> reg_rdata == transaction_id)
      else $error("transaction id read mismatch");
   // snapshot moves only after a host write
   chk_snap_hold: assert property ($changed({spread_spectrum, detect_threshold})
      |-> $past(reg_write) || $past(reg_write, 2) || $past(reg_write, 3))
      else $error("threshold changed without write");
endmodule

bind rcpd_top rcpd_assertions #(.NUM_PINS(NUM_PINS)) chk_i (
   .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .general_pin_out(general_pin_out), .general_pin_oe(general_pin_oe),
   .emitter_on(emitter_on), .standby(standby), .detect_threshold(detect_threshold),
   .spread_spectrum(spread_spectrum), .measurement_busy(measurement_busy),
   .transaction_id(transaction_id));

// [rcpd_host_model.sv]
`timescale 1ns/10ps
module rcpd_host_model (
   // clock and read data
   input  logic       clock,
   input  logic [7:0] reg_rdata,
   // register strobes
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic       reg_write,
   output logic       reg_read
);
   // bus idle at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end
   // one-cycle write strobe, one idle cycle after it
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      @(posedge clock);
      d = reg_rdata;
   endtask
   // parameters first, command last, so no half-updated set is seen
   task start(input logic [7:0] opt, pin, pul, thr, rep, lo, hi);
      wr(8'h06, (opt | 8'h03) & 8'hB7);
      wr(8'h05, pin);
      wr(8'h04, pul);
      wr(8'h03, thr & 8'h7F);
      wr(8'h02, rep);
      wr(8'h01, lo);
      wr(8'h00, hi);
      wr(8'h10, 8'h03);
   endtask
endmodule

// [test_rcpd_top.sv]
`timescale 1ns/10ps
module test_rcpd_top;
   // stimulus and observed outputs
   logic       clock, sys_rst, reg_write, reg_read, emitter_on, halving, combined;
   logic       standby, spread, busy, irq;
   logic [1:0] general_pin_in, pin_out, pin_oe;
   logic [5:0] thr;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, tid, v;
   int         err_count, checked, cyc, n, a, b;

   rcpd_top #(.LEAD_STEP_CYCLES(4), .MS_CYCLES(20), .EMIT_KITER_CYCLES(4)) uut (
      .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .general_pin_in(general_pin_in), .general_pin_out(pin_out), .general_pin_oe(pin_oe),
      .emitter_on(emitter_on), .emitter_clock_halving(halving), .combined_histogram(combined),
      .standby(standby), .detect_threshold(thr), .spread_spectrum(spread),
      .measurement_busy(busy), .measurement_irq(irq), .transaction_id(tid));
   rcpd_host_model host (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) cyc <= cyc + 1;

   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   task print_verdict;
      $display("checked %0d, errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // bounded wait for a level on the emitter (0) or first pin (1)
   task wait_lvl(input int s, input logic l, output int at);
      int i;
      for (i = 0; i < 2000 && (s ? pin_out[0] : emitter_on) !== l; i++) @(posedge clock);
      at = (i < 2000) ? cyc : -1;
   endtask
   // high time in cycles, zero if it never rises
   task width(input int s, output int w);
      wait_lvl(s, 1'b1, a);
      wait_lvl(s, 1'b0, b);
      w = (a < 0) ? 0 : b - a;
   endtask

   task t_reset;
      host.rd(8'h06, v); chk("option", 16'h0003, v);
      host.rd(8'h05, v); chk("pin_ctrl", 16'h0044, v);
      host.rd(8'h13, v); chk("tid", 16'h0000, v);
      host.rd(8'h20, v); chk("unmapped", 16'h0000, v);
      chk("pin_oe", 16'h0003, pin_oe);
      chk("pin_out", 16'h0000, pin_out);
      host.wr(8'h10, 8'h05);
      repeat (3) @(posedge clock);
      chk("other_cmd", 16'h0000, busy);
   endtask
   task t_options;
      host.wr(8'h12, 8'h01);
      host.start(8'hA4, 8'h44, 8'h00, 8'h55, 8'h00, 8'h01, 8'h00);
      width(0, n); chk("emit_half", 16'h0008, n);
      chk("halving", 16'h0001, halving);
      chk("combined", 16'h0001, combined);
      chk("thr", 16'h0015, thr);
      chk("spread", 16'h0001, spread);
      repeat (5) @(posedge clock);
      chk("irq_on", 16'h0001, irq);
      chk("tid_1", 16'h0001, tid);
      chk("single", 16'h0000, busy);
      chk("awake", 16'h0000, standby);
      host.wr(8'h11, 8'h02);
      host.wr(8'h12, 8'h00);
      host.start(8'h03, 8'h44, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00);
      width(0, n); chk("emit_full", 16'h0004, n);
      repeat (5) @(posedge clock);
      chk("irq_off", 16'h0000, irq);
      chk("tid_2", 16'h0002, tid);
      chk("asleep", 16'h0001, standby);
   endtask
   task t_iter;
      logic [7:0] lo [2] = '{8'h03, 8'h00};
      logic [15:0] ex [2] = '{16'h000C, 16'h0400};
      for (int i = 0; i < 2; i++) begin
         host.start(8'h03, 8'h44, 8'h00, 8'h00, 8'h00, lo[i], {7'h00, i[0]});
         width(0, n); chk("iter_len", ex[i], n);
      end
   endtask
   task t_pins;
      logic [7:0] pc [4] = '{8'h45, 8'h50, 8'h21, 8'h54};
      logic [1:0] oe [4] = '{2'h3, 2'h2, 2'h0, 2'h3};
      logic [1:0] hi [4] = '{2'h1, 2'h2, 2'h0, 2'h2};
      for (int i = 0; i < 4; i++) begin
         host.start(8'h03, pc[i], 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
         repeat (6) @(posedge clock);
         chk("pin_oe", oe[i], pin_oe);
         chk("pin_lvl", hi[i], pin_out & pin_oe);
      end
   endtask
   task t_marker;
      logic [7:0] pl [3] = '{8'h00, 8'h01, 8'h03};
      logic [15:0] ex [3] = '{16'h0000, 16'h0008, 16'h0010};
      for (int i = 0; i < 3; i++) begin
         host.start(8'h03, 8'h43, pl[i], 8'h00, 8'h00, 8'h02, 8'h00);
         width(1, n); chk("marker", ex[i], n);
         chk("emit_at_fall", 16'h0000, emitter_on);
      end
   endtask
   task t_gate;
      logic [7:0] t0;
      for (int c = 1; c < 3; c++) begin
         general_pin_in <= {1'b1, c == 1};
         host.wr(8'h11, 8'h02);
         host.rd(8'h13, t0);
         host.start(8'h13, 8'h40 | c[7:0], 8'h00, 8'h00, 8'h00, 8'h08, 8'h00);
         repeat (4) @(posedge clock);
         general_pin_in[0] <= (c != 1);
         repeat (6) @(posedge clock);
         chk("gated_emit", 16'h0000, emitter_on);
         host.rd(8'h11, v); chk("status_gate", 16'h0005, v);
         general_pin_in[0] <= (c == 1);
         repeat (8) @(posedge clock);
         chk("resumed", 16'h0001, emitter_on);
         host.rd(8'h11, v); chk("status_resume", 16'h0003, v);
         wait_lvl(0, 1'b0, a);
         repeat (5) @(posedge clock);
         host.rd(8'h13, v); chk("tid_once", t0 + 8'h01, v);
      end
   endtask
   task t_repeat;
      logic [7:0] lo [2] = '{8'h01, 8'h08};
      int mn [2] = '{20, 33};
      for (int i = 0; i < 2; i++) begin
         host.start(8'h03, 8'h44, 8'h00, 8'h00, 8'h01, lo[i], 8'h00);
         wait_lvl(0, 1'b1, a);
         wait_lvl(0, 1'b0, b);
         wait_lvl(0, 1'b1, a);
         n = a;
         wait_lvl(0, 1'b0, b);
         wait_lvl(0, 1'b1, b);
         chk("period", 16'h0001, (b - n >= mn[i]) && (b - n <= mn[i] + 5));
      end
      host.start(8'h03, 8'h44, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      repeat (8) @(posedge clock);
      chk("stopped", 16'h0000, busy);
   endtask

   initial begin
      err_count = 0;
      checked = 0;
      cyc = 0;
      sys_rst = 1'b1;
      general_pin_in = 2'h3;
      repeat (8) @(posedge clock);
      sys_rst <= 1'b0;
      t_reset;
      t_options;
      t_iter;
      t_pins;
      t_marker;
      t_gate;
      t_repeat;
      print_verdict;
   end
   // cut a hang short
   initial begin
      repeat (40000) @(posedge clock);
      err_count++;
      print_verdict;
   end
endmodule
